// File: bench/adc_serial_output_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sop_regs.svh"

module adc_serial_output_port_tb;
    import sop_pkg::*;
    logic clk, rst, psel, penable, pwrite, pready, pslverr;
    sop_addr_t paddr;
    sop_word_t pwdata, prdata, q;
    logic chain_o, chain_oe, sclk_o, sclk_oe, sdo, sdo_oe, mark, mark_oe;
    logic h_cs_n, h_rd_n, h_sclk, h_chain, inv, pol, cod, busy, rm, lvl, e;
    logic [15:0] res, c;
    int errors, n_checks, n;
    wire logic chain_w;
    wire logic sclk_w;
    assign chain_w = chain_oe ? chain_o : h_chain;
    assign sclk_w = sclk_oe ? sclk_o : h_sclk;

    sop_serial_port dut (.CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .CS_N(h_cs_n), .RD_N(h_rd_n),
        .CHAIN_IN_OR_READ_MODE_I(chain_w), .CHAIN_IN_OR_READ_MODE_O(chain_o),
        .CHAIN_IN_OR_READ_MODE_OE(chain_oe), .SERIAL_CLOCK_I(sclk_w),
        .SERIAL_CLOCK_O(sclk_o), .SERIAL_CLOCK_OE(sclk_oe), .SERIAL_RESULT_OUT_O(sdo),
        .SERIAL_RESULT_OUT_OE(sdo_oe), .FRAME_MARKER_O(mark), .FRAME_MARKER_OE(mark_oe));
    sop_host_model host (.cs_n(h_cs_n), .rd_n(h_rd_n), .sclk(h_sclk), .chain(h_chain),
        .sdo(sdo_oe ? sdo : !sdo));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chkw(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    task automatic chk1(input logic g, input logic x);
        chkw({31'h0, g}, {31'h0, x});
    endtask

    task automatic apb(input logic wr, input sop_addr_t a, input sop_word_t d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [15:0] coded(input logic [15:0] r, input logic straight);
        return straight ? r : r ^ 16'h8000;
    endfunction

    initial begin
        clk = 1'b0;
        forever #50 clk = !clk;
    end

    initial begin
        #1000000;
        errors++;
        report_and_stop();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {rst, psel, penable, pwrite} = 4'h8;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        n = $urandom(4693);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, `SOP_ADDR_CTRL, 32'h0);
        chkw(q, 32'h00000000);
        apb(1'b0, 8'h0C, 32'h0);
        chkw({e, q[30:0]}, 32'h80000000);
        for (int i = 0; i < 3; i++) begin
            res = 16'($urandom);
            cod = 1'($urandom);
            c = coded(res, cod);
            apb(1'b1, `SOP_ADDR_CTRL, {27'h0, cod, 4'h0});
            apb(1'b1, `SOP_ADDR_RESULT, {16'h0, res});
            @(negedge clk);
            host.enable(1'b1);
            repeat (10) @(negedge clk);
            chkw({28'h0, mark, sclk_o, sdo, chain_o}, {28'h0, c[10:7]});
            chkw({28'h0, chain_oe, sdo_oe, sclk_oe, mark_oe}, 32'hF);
            host.enable(1'b0);
            repeat (10) @(negedge clk);
        end
        for (int i = 0; i < 4; i++) begin
            res = 16'($urandom);
            {inv, pol, cod, busy, rm} = 5'($urandom);
            if (i == 0) {busy, rm} = 2'h2;
            c = coded(res, cod);
            apb(1'b1, `SOP_ADDR_CTRL, {26'h0, busy, cod, inv, pol, 2'h1});
            apb(1'b1, `SOP_ADDR_RESULT, {16'h0, res});
            @(negedge clk);
            host.chain = rm;
            host.enable(1'b1);
            if (busy && !rm) begin
                repeat (30) @(negedge clk);
                chk1(mark, pol);
                apb(1'b1, `SOP_ADDR_CTRL, {27'h0, cod, inv, pol, 2'h1});
            end
            n = 0;
            do @(negedge clk); while (mark !== !pol && n++ < 40);
            chk1(sclk_oe, 1'b1);
            for (int j = 0; j < 96; j++) begin
                if (j % 2) begin
                    chk1(sdo, c[15 - j / 6]);
                    chk1(sclk_o, inv ^ (j % 6 == 3));
                    chk1(mark, !pol);
                end
                @(negedge clk);
            end
            @(negedge clk);
            chk1(mark, pol);
            // Idle, bus enabled, result taken, sixteen bits counted
            apb(1'b0, `SOP_ADDR_STATUS, 32'h0);
            chkw(q, 32'h00001002);
            apb(1'b0, `SOP_ADDR_RESULT, 32'h0);
            chkw(q, {16'h0, res});
            @(negedge clk);
            host.enable(1'b0);
            repeat (10) @(negedge clk);
        end
        for (int i = 0; i < 3; i++) begin
            res = 16'($urandom);
            {inv, pol, cod} = 3'($urandom);
            c = coded(res, cod);
            lvl = !c[0];
            apb(1'b1, `SOP_ADDR_CTRL, {27'h0, cod, inv, pol, 2'h3});
            apb(1'b1, `SOP_ADDR_RESULT, {16'h0, res});
            repeat (5) @(negedge clk);
            chk1(sclk_oe, 1'b0);
            host.frame(inv, lvl);
            chkw({12'h0, host.got}, {12'h0, c, {4{lvl}}});
            repeat (10) @(negedge clk);
        end
        report_and_stop();
    end
endmodule

`default_nettype wire

// File: bench/sop_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module sop_host_model (
    output logic cs_n,
    output logic rd_n,
    output logic sclk,
    output logic chain,
    input wire logic sdo
);
    logic [19:0] got;

    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        sclk = 1'b0;
        chain = 1'b0;
        got = 20'h00000;
    end

    // ----------------------------------------
    // Host strobes and bit clock
    // ----------------------------------------
    task automatic enable(input logic on);
        cs_n = !on;
        rd_n = !on;
    endtask

    // Clock stands at idle outside frames; late sample covers sync delay
    task automatic frame(input logic inv, input logic lvl);
        sclk = !inv;
        chain = lvl;
        enable(1'b1);
        #1000;
        for (int i = 0; i < 20; i++) begin
            sclk = inv;
            #200 got[19-i] = sdo;
            #200 sclk = !inv;
            #400;
        end
        enable(1'b0);
    endtask
endmodule

`default_nettype wire

// File: hw/sop_pkg.sv
`include "sop_regs.svh"

package sop_pkg;
    typedef logic [31:0] sop_word_t;
    typedef logic [7:0] sop_addr_t;
    typedef logic [`SOP_WORD_BITS-1:0] sop_result_t;
    typedef enum logic [2:0] {
        SOP_ST_IDLE = 3'h1,
        SOP_ST_INT = 3'h2,
        SOP_ST_EXT = 3'h4
    } sop_state_e;
endpackage

// File: hw/sop_regs.svh
`ifndef SOP_REGS_SVH
`define SOP_REGS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define SOP_ADDR_CTRL 8'h00
`define SOP_ADDR_RESULT 8'h04
`define SOP_ADDR_STATUS 8'h08

// ----------------------------------------
// Control fields
// ----------------------------------------
`define SOP_CTRL_PORT_STYLE 0
`define SOP_CTRL_CLK_SOURCE 1
`define SOP_CTRL_MARKER_POL 2
`define SOP_CTRL_CLK_INVERT 3
`define SOP_CTRL_CODING 4
`define SOP_CTRL_CONV_BUSY 5
`define SOP_CTRL_MSB 5
`define SOP_CTRL_RESET 6'h00
`define SOP_RESULT_RESET 16'h0000

// ----------------------------------------
// Status fields
// ----------------------------------------
`define SOP_STAT_ACTIVE 0
`define SOP_STAT_BUS_EN 1
`define SOP_STAT_FRESH 2
`define SOP_STAT_CNT_LSB 8
`define SOP_STAT_CNT_MSB 12

// ----------------------------------------
// Result word and timing
// ----------------------------------------
`define SOP_WORD_BITS 16
`define SOP_LAST_BIT 5'h0F
`define SOP_PAR_BIT_SEVEN 7
`define SOP_PAR_BIT_EIGHT 8
`define SOP_PAR_BIT_NINE 9
`define SOP_PAR_BIT_TEN 10
`define SOP_PHASE_LOW 2'h0
`define SOP_PHASE_HIGH 2'h1
`define SOP_PHASE_HOLD 2'h2
`define SOP_CLK_PERIOD_NS 100
`define SOP_INT_PHASE_NS 200
`define SOP_INT_PHASE_CYC \
    ((`SOP_INT_PHASE_NS + `SOP_CLK_PERIOD_NS - 1) / `SOP_CLK_PERIOD_NS)

`endif

// File: hw/sop_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "sop_regs.svh"

module sop_serial_port (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire sop_pkg::sop_addr_t PADDR,
    input wire sop_pkg::sop_word_t PWDATA,
    output sop_pkg::sop_word_t PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic CS_N,
    input wire logic RD_N,
    input wire logic CHAIN_IN_OR_READ_MODE_I,
    output logic CHAIN_IN_OR_READ_MODE_O,
    output logic CHAIN_IN_OR_READ_MODE_OE,
    input wire logic SERIAL_CLOCK_I,
    output logic SERIAL_CLOCK_O,
    output logic SERIAL_CLOCK_OE,
    output logic SERIAL_RESULT_OUT_O,
    output logic SERIAL_RESULT_OUT_OE,
    output logic FRAME_MARKER_O,
    output logic FRAME_MARKER_OE
);
    import sop_pkg::*;

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [`SOP_CTRL_MSB:0] ctrl_q;
    sop_result_t result_q, coded;
    sop_word_t prdata_q;
    logic fresh_q, pready_q, pslverr_q, apb_wr, apb_rd_data;
    logic port_style_select, clock_source_select, frame_marker_polarity;
    logic bit_clock_invert, output_coding_select, conv_busy;

    assign port_style_select = ctrl_q[`SOP_CTRL_PORT_STYLE];
    assign clock_source_select = ctrl_q[`SOP_CTRL_CLK_SOURCE];
    assign frame_marker_polarity = ctrl_q[`SOP_CTRL_MARKER_POL];
    assign bit_clock_invert = ctrl_q[`SOP_CTRL_CLK_INVERT];
    assign output_coding_select = ctrl_q[`SOP_CTRL_CODING];
    assign conv_busy = ctrl_q[`SOP_CTRL_CONV_BUSY];
    // Twos complement by MSB inversion when coding select is low
    assign coded = {result_q[`SOP_WORD_BITS-1] ^ ~output_coding_select,
                    result_q[`SOP_WORD_BITS-2:0]};

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [1:0] cs_sync_q, rd_sync_q, pin_sync_q, sclk_sync_q;
    logic sclk_prev_q, bus_en_q, bus_en, chain_lvl, upd_edge;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            cs_sync_q <= 2'h3;
            rd_sync_q <= 2'h3;
            pin_sync_q <= 2'h0;
            sclk_sync_q <= 2'h0;
            sclk_prev_q <= 1'b0;
            bus_en_q <= 1'b0;
        end else begin
            cs_sync_q <= {cs_sync_q[0], CS_N};
            rd_sync_q <= {rd_sync_q[0], RD_N};
            pin_sync_q <= {pin_sync_q[0], CHAIN_IN_OR_READ_MODE_I};
            sclk_sync_q <= {sclk_sync_q[0], SERIAL_CLOCK_I};
            sclk_prev_q <= sclk_sync_q[1];
            bus_en_q <= bus_en;
        end
    end

    assign bus_en = ~cs_sync_q[1] & ~rd_sync_q[1];
    assign chain_lvl = pin_sync_q[1];
    // Rising edge, or falling edge when inverted
    assign upd_edge = (sclk_sync_q[1] ^ sclk_prev_q)
                      & (sclk_sync_q[1] ^ bit_clock_invert);

    // ----------------------------------------
    // Read sequencer
    // ----------------------------------------
    sop_state_e state_q;
    sop_result_t shift_q;
    logic [4:0] bit_cnt_q;
    logic [1:0] phase_q;
    logic [1:0] tick_q;
    logic tick_done, start_int, start_ext, first_chain_q;

    assign tick_done = (tick_q == 2'(`SOP_INT_PHASE_CYC - 1));
    assign start_int = (state_q == SOP_ST_IDLE) & port_style_select & ~clock_source_select
                       & bus_en & fresh_q & (chain_lvl | ~conv_busy);
    assign start_ext = (state_q == SOP_ST_IDLE) & port_style_select & clock_source_select
                       & bus_en & ~bus_en_q;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            state_q <= SOP_ST_IDLE;
        end else begin
            case (state_q)
                SOP_ST_IDLE: begin
                    if (start_int) begin
                        state_q <= SOP_ST_INT;
                    end else if (start_ext) begin
                        state_q <= SOP_ST_EXT;
                    end
                end
                SOP_ST_INT: begin
                    if (~port_style_select | clock_source_select) begin
                        state_q <= SOP_ST_IDLE;
                    end else if (tick_done & (phase_q == `SOP_PHASE_HOLD)
                                 & (bit_cnt_q == `SOP_LAST_BIT)) begin
                        state_q <= SOP_ST_IDLE;
                    end
                end
                SOP_ST_EXT: begin
                    if (~bus_en | ~port_style_select | ~clock_source_select) begin
                        state_q <= SOP_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= SOP_ST_IDLE;
                end
            endcase
        end
    end

    // Internal clock: low, high, low phases so both edges see stable data
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            tick_q <= 2'h0;
            phase_q <= `SOP_PHASE_LOW;
        end else if (state_q != SOP_ST_INT) begin
            tick_q <= 2'h0;
            phase_q <= `SOP_PHASE_LOW;
        end else if (tick_done) begin
            tick_q <= 2'h0;
            phase_q <= (phase_q == `SOP_PHASE_HOLD) ? `SOP_PHASE_LOW : phase_q + 2'h1;
        end else begin
            tick_q <= tick_q + 2'h1;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            shift_q <= `SOP_RESULT_RESET;
            bit_cnt_q <= 5'h00;
        end else if (start_int | start_ext) begin
            shift_q <= coded;
            bit_cnt_q <= 5'h00;
        end else if ((state_q == SOP_ST_INT) & tick_done & (phase_q == `SOP_PHASE_HOLD)) begin
            shift_q <= {shift_q[`SOP_WORD_BITS-2:0], 1'b0};
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end else if ((state_q == SOP_ST_EXT) & upd_edge) begin
            // Chain level enters at the bottom, reaching the output after 16 shifts
            shift_q <= {shift_q[`SOP_WORD_BITS-2:0], chain_lvl};
            if (bit_cnt_q != 5'h1F) begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            first_chain_q <= 1'b0;
        end else if ((state_q == SOP_ST_EXT) & upd_edge & (bit_cnt_q == 5'h00)) begin
            first_chain_q <= chain_lvl;
        end
    end

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    logic sdo_q, sdo_oe_q, frame_q, frame_oe_q;
    logic sclk_q, sclk_oe_q, chain_q, chain_oe_q;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            sdo_q <= 1'b0;
            sdo_oe_q <= 1'b0;
            frame_q <= 1'b0;
            frame_oe_q <= 1'b0;
            sclk_q <= 1'b0;
            sclk_oe_q <= 1'b0;
            chain_q <= 1'b0;
            chain_oe_q <= 1'b0;
        end else if (~port_style_select) begin
            sdo_q <= coded[`SOP_PAR_BIT_EIGHT];
            frame_q <= coded[`SOP_PAR_BIT_TEN];
            sclk_q <= coded[`SOP_PAR_BIT_NINE];
            chain_q <= coded[`SOP_PAR_BIT_SEVEN];
            sdo_oe_q <= bus_en;
            frame_oe_q <= bus_en;
            sclk_oe_q <= bus_en;
            chain_oe_q <= bus_en;
        end else begin
            sdo_q <= shift_q[`SOP_WORD_BITS-1];
            sdo_oe_q <= bus_en;
            frame_q <= ~clock_source_select & (state_q == SOP_ST_INT)
                       ^ frame_marker_polarity;
            frame_oe_q <= bus_en;
            sclk_q <= (phase_q == `SOP_PHASE_HIGH) & (state_q == SOP_ST_INT)
                      ^ bit_clock_invert;
            sclk_oe_q <= ~clock_source_select;
            chain_q <= 1'b0;
            chain_oe_q <= 1'b0;
        end
    end

    assign SERIAL_RESULT_OUT_O = sdo_q;
    assign SERIAL_RESULT_OUT_OE = sdo_oe_q;
    assign FRAME_MARKER_O = frame_q;
    assign FRAME_MARKER_OE = frame_oe_q;
    assign SERIAL_CLOCK_O = sclk_q;
    assign SERIAL_CLOCK_OE = sclk_oe_q;
    assign CHAIN_IN_OR_READ_MODE_O = chain_q;
    assign CHAIN_IN_OR_READ_MODE_OE = chain_oe_q;

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    assign apb_wr = PSEL & PENABLE & PWRITE & pready_q;
    assign apb_rd_data = PSEL & PENABLE & ~pready_q;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (apb_rd_data) begin
            pready_q <= 1'b1;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            if (PADDR == `SOP_ADDR_CTRL) begin
                prdata_q[`SOP_CTRL_MSB:0] <= ctrl_q;
            end else if (PADDR == `SOP_ADDR_RESULT) begin
                prdata_q[`SOP_WORD_BITS-1:0] <= result_q;
            end else if (PADDR == `SOP_ADDR_STATUS) begin
                prdata_q[`SOP_STAT_ACTIVE] <= (state_q != SOP_ST_IDLE);
                prdata_q[`SOP_STAT_BUS_EN] <= bus_en;
                prdata_q[`SOP_STAT_FRESH] <= fresh_q;
                prdata_q[`SOP_STAT_CNT_MSB:`SOP_STAT_CNT_LSB] <= bit_cnt_q;
            end else begin
                pslverr_q <= 1'b1;
            end
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign PRDATA = prdata_q;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ctrl_q <= `SOP_CTRL_RESET;
            result_q <= `SOP_RESULT_RESET;
        end else if (apb_wr & (PADDR == `SOP_ADDR_CTRL)) begin
            ctrl_q <= PWDATA[`SOP_CTRL_MSB:0];
        end else if (apb_wr & (PADDR == `SOP_ADDR_RESULT)) begin
            result_q <= PWDATA[`SOP_WORD_BITS-1:0];
        end
    end

    // New result waiting; a write in the start cycle wins
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            fresh_q <= 1'b0;
        end else if (apb_wr & (PADDR == `SOP_ADDR_RESULT)) begin
            fresh_q <= 1'b1;
        end else if (start_int) begin
            fresh_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_parallel_bits: assert property (@(posedge CLK) disable iff (RESET)
        (~port_style_select & ~apb_wr) |=>
        (CHAIN_IN_OR_READ_MODE_O == coded[`SOP_PAR_BIT_SEVEN])
        && (SERIAL_RESULT_OUT_O == coded[`SOP_PAR_BIT_EIGHT])
        && (FRAME_MARKER_O == coded[`SOP_PAR_BIT_TEN]))
        else $error("parallel bits wrong");
    a_chain_pin_input: assert property (@(posedge CLK) disable iff (RESET)
        port_style_select |=> ~CHAIN_IN_OR_READ_MODE_OE)
        else $error("chain pin driven in serial mode");
    a_chain_forward: assert property (@(posedge CLK) disable iff (RESET)
        ((state_q == SOP_ST_EXT) & upd_edge & (bit_cnt_q == `SOP_LAST_BIT)) |=>
        (shift_q[`SOP_WORD_BITS-1] == first_chain_q))
        else $error("chain level not forwarded after 16 periods");
    a_read_mode_gate: assert property (@(posedge CLK) disable iff (RESET)
        ((state_q == SOP_ST_INT) & ($past(state_q) == SOP_ST_IDLE)) |->
        ($past(chain_lvl) | ~$past(conv_busy)))
        else $error("read started during conversion");
    a_msb_first_load: assert property (@(posedge CLK) disable iff (RESET)
        (start_int | start_ext) |=> (shift_q == $past(coded)) ##1
        (SERIAL_RESULT_OUT_O == shift_q[`SOP_WORD_BITS-1]) || ~port_style_select)
        else $error("result not loaded MSB first");
    a_int_bit_stable: assert property (@(posedge CLK) disable iff (RESET)
        ((state_q == SOP_ST_INT) & (phase_q != `SOP_PHASE_HOLD)) |=> $stable(shift_q))
        else $error("data moved across a serial clock edge");
    a_ext_update_edge: assert property (@(posedge CLK) disable iff (RESET)
        ((state_q == SOP_ST_EXT) & ~upd_edge) |=> $stable(shift_q))
        else $error("data changed off the update edge");
    a_clock_pin_dir: assert property (@(posedge CLK) disable iff (RESET)
        port_style_select |=> (SERIAL_CLOCK_OE == ~$past(clock_source_select)))
        else $error("serial clock direction wrong");
    a_frame_marker: assert property (@(posedge CLK) disable iff (RESET)
        (port_style_select & ~clock_source_select) |=>
        (FRAME_MARKER_O == (($past(state_q) == SOP_ST_INT) ^ $past(frame_marker_polarity))))
        else $error("frame marker wrong");
endmodule

`default_nettype wire
